// ===== ams_host_model.sv
// host controller model driving the serial pins of the mode sequencer
`timescale 1ns/1ps
module ams_host_model (
  // clock
  input  wire logic sys_clk,
  // serial pins
  output logic      ser_cs_n,
  output logic      ser_sclk,
  output logic      ser_din,
  input  wire logic dout_rdy_n
);
  import ams_pkg::*;

  initial begin
    ser_cs_n = 1'b1;
    ser_sclk = 1'b1;
    ser_din  = 1'b1;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic sel(input logic on);
    cyc(5);
    ser_cs_n = ~on;
    cyc(5);
  endtask

  // msb first, each sclk half lasts 5 cycles, bit sampled before the rising edge
  task automatic shift(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      ser_sclk = 1'b0;
      ser_din  = tx[i];
      cyc(5);
      rx[i]    = dout_rdy_n;
      ser_sclk = 1'b1;
      cyc(5);
    end
  endtask

  task automatic wr_mode(input logic [23:0] v);
    logic [31:0] rx;
    sel(1'b1);
    shift(8, {26'h0, RS_MODE, 3'h0}, rx);
    shift(24, {8'h0, v & ~MODE_RSV_MASK}, rx);
    sel(1'b0);
  endtask

  task automatic rd(input logic [2:0] rs, input int n, output logic [31:0] rx);
    sel(1'b1);
    shift(8, {24'h0, 2'b01, rs, 3'h0}, rx);
    shift(n, 32'h0, rx);
    sel(1'b0);
  endtask
endmodule

// ===== ams_mode_sequencer.sv
// operating mode register, serial access and conversion sequencing of the converter
`timescale 1ns/1ps
module ams_mode_sequencer #(
  parameter int unsigned WAKE_CYCLES = ams_pkg::WAKE_CYCLES_DEF
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  // serial port pins
  input  wire logic              ser_cs_n,
  input  wire logic              ser_sclk,
  input  wire logic              ser_din,
  output logic                   dout_rdy_n,
  output logic                   dout_oe,
  // configuration held elsewhere
  input  wire logic              chop_en,
  input  wire logic [7:0]        channel_enable_bits,
  input  wire logic [2:0]        result_channel_tag,
  // analog front end
  input  wire logic [23:0]       afe_result,
  input  wire logic              afe_err,
  output ams_pkg::ams_ctrl_s     afe_ctrl,
  output logic                   cal_store,
  output logic                   cal_is_gain
);
  import ams_pkg::*;

  // ****************************************
  // reset release and pin synchronisers
  // ****************************************
  logic [1:0]  rst_sync_ff;
  logic        rst_n;
  logic [2:0]  pins_s;
  logic        cs_n_s, sclk_s, din_s, sclk_rise;
  ams_state_s  cur_ff;
  ams_state_s  nxt_st;
  ams_opmode_e opm;
  logic [1:0]  clk_src;
  logic [9:0]  rate_code;
  logic [2:0]  order, need;
  logic [11:0] per_target;
  logic        multi_chan, zl_active, tick, per_end;
  logic [7:0]  status;
  logic        mode_wr, read_done, new_result;
  logic [7:0]  cmd;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  ams_sync3 u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({ser_cs_n, ser_sclk, ser_din}),
    .sync_out (pins_s)
  );
  assign {cs_n_s, sclk_s, din_s} = pins_s;
  assign sclk_rise               = sclk_s & ~cur_ff.sclk_q;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [5:0] reg_len(input logic [2:0] a, input logic sta);
    reg_len = (a == RS_DATA) ? (sta ? LEN_WORD_STA : LEN_WORD) :
              (a == RS_STATUS || a == RS_ID || a == RS_GPO) ? LEN_BYTE : LEN_WORD;
  endfunction

  function automatic ams_conv_e start_state(input logic [2:0] m);
    case (m)
      OPM_CONT:   start_state = CV_SETTLE;
      OPM_SINGLE: start_state = CV_WAKE;
      OPM_IDLE:   start_state = CV_IDLE;
      OPM_PDOWN:  start_state = CV_PDOWN;
      default:    start_state = CV_SETTLE;
    endcase
  endfunction

  assign opm        = ams_opmode_e'(cur_ff.mode[MR_MODE_HI:MR_MODE_LO]);
  assign clk_src    = cur_ff.mode[MR_CLK_HI:MR_CLK_LO];
  assign rate_code  = (cur_ff.mode[MR_FS_HI:0] == 10'h000) ? 10'h001 : cur_ff.mode[MR_FS_HI:0];
  assign order      = cur_ff.mode[MR_THIRD_ORDER_FILTER_SEL] ? ORDER_THIRD_ORDER_FILTER_SEL : ORDER_SINC4;
  assign multi_chan = (channel_enable_bits & (channel_enable_bits - 8'h01)) != 8'h00;
  assign zl_active  = cur_ff.mode[MR_ZL] & ~multi_chan & (opm != OPM_SINGLE);
  assign need       = (zl_active && opm == OPM_CONT) ? ZL_PERIODS : order;
  assign per_target = chop_en ? 12'(order * rate_code) : {2'h0, rate_code};
  assign tick       = cur_ff.div_cnt == MOD_DIV_LAST;
  assign per_end    = tick && (cur_ff.per_cnt >= per_target - 12'h001);
  assign status     = {cur_ff.rdy_n, cur_ff.err, 1'b0,
                       cur_ff.mode[MR_PAR] & ^cur_ff.data, 1'b0, cur_ff.tag};

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_st           = cur_ff;
    nxt_st.cal_store = 1'b0;
    nxt_st.sclk_q    = sclk_s;
    mode_wr          = 1'b0;
    read_done        = 1'b0;
    new_result       = 1'b0;
    cmd              = {cur_ff.in_sh[6:0], din_s};
    // serial port
    if (cs_n_s) begin
      nxt_st.phase   = PH_CMD;
      nxt_st.bit_cnt = 6'h00;
    end else if (sclk_rise) begin
      nxt_st.in_sh = {cur_ff.in_sh[22:0], din_s};
      case (cur_ff.phase)
        PH_CMD: begin
          if (cur_ff.bit_cnt == 6'h00 && din_s) begin
            nxt_st.in_sh = cur_ff.in_sh;
          end else if (cur_ff.bit_cnt == LEN_BYTE - 6'h01) begin
            nxt_st.bit_cnt = 6'h00;
            nxt_st.addr    = cmd[CR_RS_HI:CR_RS_LO];
            nxt_st.len     = reg_len(cmd[CR_RS_HI:CR_RS_LO], cur_ff.mode[MR_STA]);
            if (cur_ff.continuous_read_en) begin
              if (cmd == CMD_CONTINUOUS_READ_EN_OFF && !cur_ff.rdy_n) begin
                nxt_st.continuous_read_en = 1'b0;
              end
            end else if (cmd[CR_RW]) begin
              nxt_st.phase = PH_RD;
              nxt_st.continuous_read_en = (cmd == CMD_CONTINUOUS_READ_EN_ON);
              case (cmd[CR_RS_HI:CR_RS_LO])
                RS_STATUS: nxt_st.out_sh = {status, 24'h000000};
                RS_MODE:   nxt_st.out_sh = {cur_ff.mode, 8'h00};
                RS_DATA:   nxt_st.out_sh = {cur_ff.data, status};
                default:   nxt_st.out_sh = 32'h00000000;
              endcase
            end else begin
              nxt_st.phase = PH_WR;
            end
          end else begin
            nxt_st.bit_cnt = cur_ff.bit_cnt + 6'h01;
          end
        end
        PH_WR: begin
          if (cur_ff.bit_cnt == cur_ff.len - 6'h01) begin
            nxt_st.phase   = PH_CMD;
            nxt_st.bit_cnt = 6'h00;
            if (cur_ff.addr == RS_MODE) begin
              mode_wr = 1'b1;
            end
          end else begin
            nxt_st.bit_cnt = cur_ff.bit_cnt + 6'h01;
          end
        end
        PH_RD: begin
          nxt_st.out_sh = {cur_ff.out_sh[30:0], 1'b0};
          if (cur_ff.continuous_read_en && cur_ff.bit_cnt == LEN_BYTE - 6'h01 && cmd == CMD_CONTINUOUS_READ_EN_OFF && !cur_ff.rdy_n) begin
            nxt_st.continuous_read_en = 1'b0;
          end
          if (cur_ff.bit_cnt == cur_ff.len - 6'h01) begin
            nxt_st.phase   = PH_CMD;
            nxt_st.bit_cnt = 6'h00;
            read_done      = cur_ff.addr == RS_DATA;
          end else begin
            nxt_st.bit_cnt = cur_ff.bit_cnt + 6'h01;
          end
        end
        default: begin
          nxt_st.phase   = PH_CMD;
          nxt_st.bit_cnt = 6'h00;
        end
      endcase
    end
    // conversion sequencing
    if (read_done) begin
      nxt_st.rdy_n = 1'b1;
    end
    if (mode_wr) begin
      nxt_st.mode     = nxt_st.in_sh & ~MODE_RSV_MASK;
      nxt_st.conv     = start_state(nxt_st.in_sh[MR_MODE_HI:MR_MODE_LO]);
      nxt_st.div_cnt  = 10'h000;
      nxt_st.per_cnt  = 12'h000;
      nxt_st.set_cnt  = 3'h0;
      nxt_st.wake_cnt = 14'h0000;
      nxt_st.rdy_n    = 1'b1;
    end else begin
      if (cur_ff.conv == CV_SETTLE || cur_ff.conv == CV_RUN) begin
        nxt_st.div_cnt = tick ? 10'h000 : cur_ff.div_cnt + 10'h001;
        if (tick) begin
          nxt_st.per_cnt = per_end ? 12'h000 : cur_ff.per_cnt + 12'h001;
        end
      end
      case (cur_ff.conv)
        CV_IDLE, CV_PDOWN: begin
          nxt_st.div_cnt = 10'h000;
        end
        CV_WAKE: begin
          if (cur_ff.wake_cnt == 14'(WAKE_CYCLES - 1)) begin
            nxt_st.conv     = CV_SETTLE;
            nxt_st.wake_cnt = 14'h0000;
          end else begin
            nxt_st.wake_cnt = cur_ff.wake_cnt + 14'h0001;
          end
        end
        CV_SETTLE: begin
          if (per_end) begin
            if (cur_ff.set_cnt == need - 3'h1) begin
              nxt_st.set_cnt = 3'h0;
              if (opm[2]) begin
                nxt_st.cal_store   = 1'b1;
                nxt_st.cal_is_gain = opm[0];
                nxt_st.rdy_n       = 1'b0;
                nxt_st.mode[MR_MODE_HI:MR_MODE_LO] = OPM_IDLE;
                nxt_st.conv        = CV_IDLE;
              end else begin
                new_result  = 1'b1;
                nxt_st.conv = (opm == OPM_SINGLE) ? CV_PDOWN : CV_RUN;
              end
            end else begin
              nxt_st.set_cnt = cur_ff.set_cnt + 3'h1;
            end
          end
        end
        CV_RUN: begin
          new_result = per_end;
        end
        default: begin
          nxt_st.conv = CV_IDLE;
        end
      endcase
      if (new_result) begin
        nxt_st.data  = afe_result;
        nxt_st.err   = afe_err;
        nxt_st.tag   = result_channel_tag;
        nxt_st.rdy_n = 1'b0;
        if (cur_ff.continuous_read_en && !cs_n_s && nxt_st.phase == PH_CMD && nxt_st.bit_cnt == 6'h00) begin
          nxt_st.phase  = PH_RD;
          nxt_st.addr   = RS_DATA;
          nxt_st.len    = reg_len(RS_DATA, cur_ff.mode[MR_STA]);
          nxt_st.out_sh = {afe_result, 1'b0, afe_err, 1'b0,
                           cur_ff.mode[MR_PAR] & ^afe_result, 1'b0, result_channel_tag};
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff       <= '0;
      cur_ff.mode  <= MODE_RESET;
      cur_ff.conv  <= CV_SETTLE;
      cur_ff.phase <= PH_CMD;
      cur_ff.rdy_n <= 1'b1;
      cur_ff.sclk_q <= 1'b1;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign dout_oe     = ~cs_n_s;
  assign dout_rdy_n  = (cur_ff.phase == PH_RD) ? cur_ff.out_sh[31] : cur_ff.rdy_n;
  assign cal_store   = cur_ff.cal_store;
  assign cal_is_gain = cur_ff.cal_is_gain;

  always_comb begin
    afe_ctrl.filter_reset   = cur_ff.conv != CV_SETTLE && cur_ff.conv != CV_RUN;
    afe_ctrl.analog_pd      = cur_ff.conv == CV_PDOWN;
    afe_ctrl.input_short    = opm == OPM_IZERO;
    afe_ctrl.fs_connect     = opm == OPM_IFULL;
    afe_ctrl.third_order    = cur_ff.mode[MR_THIRD_ORDER_FILTER_SEL];
    afe_ctrl.notch_sixty_on = cur_ff.mode[MR_NOTCH_SIXTY_EN] && rate_code == NOTCH50_CODE;
    afe_ctrl.parity_on      = cur_ff.mode[MR_PAR];
    afe_ctrl.xtal_en        = clk_src == CLK_XTAL;
    afe_ctrl.int_osc_en     = clk_src[1] && cur_ff.conv != CV_PDOWN;
    afe_ctrl.mclk_b_oe      = clk_src == CLK_INT_OUT && cur_ff.conv != CV_PDOWN;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_MODE_WRITE_RDY: assert property (mode_wr |=> cur_ff.rdy_n && cur_ff.div_cnt == 10'h000)
    else $error("mode write did not raise ready");
  AST_STA_LEN: assert property (read_done |-> cur_ff.len == (cur_ff.mode[MR_STA] ? LEN_WORD_STA : LEN_WORD))
    else $error("data read length wrong");
  AST_PARITY: assert property (new_result |=> status[4] == (cur_ff.mode[MR_PAR] && ^$past(afe_result)))
    else $error("parity bit wrong");
  AST_PD_XTAL: assert property (cur_ff.conv == CV_PDOWN |-> afe_ctrl.analog_pd &&
                                afe_ctrl.xtal_en == (clk_src == CLK_XTAL) && !afe_ctrl.mclk_b_oe)
    else $error("power-down clock control wrong");
  AST_SINGLE_END: assert property (new_result && opm == OPM_SINGLE |=> cur_ff.conv == CV_PDOWN && !cur_ff.rdy_n)
    else $error("single conversion did not power down");
  AST_HOLD_RDY: assert property (cur_ff.conv == CV_PDOWN && !cur_ff.rdy_n && !read_done && !mode_wr
                                 |=> !cur_ff.rdy_n && $stable(cur_ff.data))
    else $error("single result not held");
  AST_CAL_IDLE: assert property ($rose(cur_ff.cal_store) |-> cur_ff.conv == CV_IDLE &&
                                 cur_ff.mode[MR_MODE_HI:MR_MODE_LO] == OPM_IDLE && !cur_ff.rdy_n)
    else $error("calibration did not end in idle");
  AST_NOTCH: assert property (afe_ctrl.notch_sixty_on |-> cur_ff.mode[MR_FS_HI:0] == NOTCH50_CODE)
    else $error("sixty hertz notch at wrong code");
  AST_RUN_PERIOD: assert property (cur_ff.conv == CV_RUN && per_end && !mode_wr
                                   |=> !cur_ff.rdy_n && cur_ff.per_cnt == 12'h000)
    else $error("continuous result not flagged");
  AST_IDLE_RESET: assert property (opm == OPM_IDLE && cur_ff.conv == CV_IDLE |-> afe_ctrl.filter_reset)
    else $error("idle without filter reset");
endmodule

// ===== ams_pkg.sv
// shared constants, enumerations and carriers of the converter mode sequencer
package ams_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned SYS_CLK_HZ      = 10_000_000;
  localparam int unsigned WAKE_TIME_US    = 1000;
  localparam int unsigned WAKE_CYCLES_DEF = (SYS_CLK_HZ / 1_000_000) * WAKE_TIME_US;
  localparam int unsigned MOD_DIV         = 1024;
  localparam logic [9:0]  MOD_DIV_LAST    = 10'(MOD_DIV - 1);
  localparam int unsigned MCLK_NOM_HZ     = 4_920_000;
  localparam int unsigned NOTCH_BASE_HZ   = 50;
  localparam logic [9:0]  NOTCH50_CODE    = 10'(MCLK_NOM_HZ / MOD_DIV / NOTCH_BASE_HZ);
  localparam logic [2:0]  ORDER_THIRD_ORDER_FILTER_SEL     = 3'h3;
  localparam logic [2:0]  ORDER_SINC4     = 3'h4;
  localparam logic [2:0]  ZL_PERIODS      = 3'h1;

  // ****************************************
  // operating_mode_control layout
  // ****************************************
  localparam logic [23:0] MODE_RESET    = 24'h080060;
  localparam logic [23:0] MODE_RSV_MASK = 24'h035000;
  localparam int unsigned MR_MODE_HI    = 23;
  localparam int unsigned MR_MODE_LO    = 21;
  localparam int unsigned MR_STA        = 20;
  localparam int unsigned MR_CLK_HI     = 19;
  localparam int unsigned MR_CLK_LO     = 18;
  localparam int unsigned MR_THIRD_ORDER_FILTER_SEL      = 15;
  localparam int unsigned MR_PAR        = 13;
  localparam int unsigned MR_ZL         = 11;
  localparam int unsigned MR_NOTCH_SIXTY_EN      = 10;
  localparam int unsigned MR_FS_HI      = 9;

  typedef enum logic [2:0] {
    OPM_CONT   = 3'h0,
    OPM_SINGLE = 3'h1,
    OPM_IDLE   = 3'h2,
    OPM_PDOWN  = 3'h3,
    OPM_IZERO  = 3'h4,
    OPM_IFULL  = 3'h5,
    OPM_SZERO  = 3'h6,
    OPM_SFULL  = 3'h7
  } ams_opmode_e;

  localparam logic [1:0] CLK_XTAL    = 2'h0;
  localparam logic [1:0] CLK_EXT     = 2'h1;
  localparam logic [1:0] CLK_INT     = 2'h2;
  localparam logic [1:0] CLK_INT_OUT = 2'h3;

  // ****************************************
  // serial command byte
  // ****************************************
  localparam logic [7:0]  CMD_CONTINUOUS_READ_EN_ON  = 8'h5c;
  localparam logic [7:0]  CMD_CONTINUOUS_READ_EN_OFF = 8'h58;
  localparam int unsigned CR_RW         = 6;
  localparam int unsigned CR_RS_HI      = 5;
  localparam int unsigned CR_RS_LO      = 3;
  localparam int unsigned CR_CONTINUOUS_READ_EN      = 2;
  localparam logic [2:0]  RS_STATUS     = 3'h0;
  localparam logic [2:0]  RS_MODE       = 3'h1;
  localparam logic [2:0]  RS_DATA       = 3'h3;
  localparam logic [2:0]  RS_ID         = 3'h4;
  localparam logic [2:0]  RS_GPO        = 3'h5;
  localparam logic [5:0]  LEN_BYTE      = 6'h08;
  localparam logic [5:0]  LEN_WORD      = 6'h18;
  localparam logic [5:0]  LEN_WORD_STA  = 6'h20;

  // ****************************************
  // state machines and carriers
  // ****************************************
  typedef enum logic [4:0] {
    CV_IDLE   = 5'h01,
    CV_PDOWN  = 5'h02,
    CV_WAKE   = 5'h04,
    CV_SETTLE = 5'h08,
    CV_RUN    = 5'h10
  } ams_conv_e;

  typedef enum logic [2:0] {
    PH_CMD = 3'h1,
    PH_WR  = 3'h2,
    PH_RD  = 3'h4
  } ams_phase_e;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
  } ams_sync_s;

  typedef struct packed {
    logic filter_reset;
    logic analog_pd;
    logic input_short;
    logic fs_connect;
    logic third_order;
    logic notch_sixty_on;
    logic parity_on;
    logic xtal_en;
    logic int_osc_en;
    logic mclk_b_oe;
  } ams_ctrl_s;

  typedef struct packed {
    logic [23:0] mode;
    ams_conv_e   conv;
    ams_phase_e  phase;
    logic [23:0] in_sh;
    logic [31:0] out_sh;
    logic [5:0]  bit_cnt;
    logic [5:0]  len;
    logic [2:0]  addr;
    logic        continuous_read_en;
    logic [9:0]  div_cnt;
    logic [11:0] per_cnt;
    logic [2:0]  set_cnt;
    logic [13:0] wake_cnt;
    logic [23:0] data;
    logic        err;
    logic [2:0]  tag;
    logic        rdy_n;
    logic        cal_store;
    logic        cal_is_gain;
    logic        sclk_q;
  } ams_state_s;

endpackage

// ===== ams_sync3.sv
// two-flop synchroniser for the three serial pins
`timescale 1ns/1ps
module ams_sync3 (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // pins in, synchronised out
  input  wire logic [2:0] async_in,
  output logic      [2:0] sync_out
);
  import ams_pkg::*;

  ams_sync_s cur_ff;
  ams_sync_s nxt_st;

  always_comb begin
    nxt_st.s1 = async_in;
    nxt_st.s2 = cur_ff.s1;
  end

  // pins idle high: cs, sclk and din all rest at one
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '{s1: 3'h7, s2: 3'h7};
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign sync_out = cur_ff.s2;
endmodule

// ===== tb_top.sv
// self-checking bench of the converter mode sequencer
`timescale 1ns/1ps
module tb_top;
  import ams_pkg::*;
  localparam int unsigned WAKE = 20;
  logic        sys_clk, reset_n, ser_cs_n, ser_sclk, ser_din;
  logic        dout_rdy_n, dout_oe, chop_en, afe_err, cal_store, cal_is_gain;
  logic [7:0]  channel_enable_bits;
  logic [2:0]  result_channel_tag;
  logic [23:0] afe_result;
  ams_ctrl_s   afe_ctrl;
  int          num_errors = 0;
  int          checks = 0;

  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  ams_mode_sequencer #(.WAKE_CYCLES(WAKE)) i_ams_mode_sequencer (
    .sys_clk(sys_clk), .reset_n(reset_n), .ser_cs_n(ser_cs_n), .ser_sclk(ser_sclk),
    .ser_din(ser_din), .dout_rdy_n(dout_rdy_n), .dout_oe(dout_oe), .chop_en(chop_en),
    .channel_enable_bits(channel_enable_bits), .result_channel_tag(result_channel_tag),
    .afe_result(afe_result), .afe_err(afe_err), .afe_ctrl(afe_ctrl), .cal_store(cal_store),
    .cal_is_gain(cal_is_gain));

  ams_host_model i_ams_host_model (
    .sys_clk(sys_clk), .ser_cs_n(ser_cs_n), .ser_sclk(ser_sclk), .ser_din(ser_din),
    .dout_rdy_n(dout_rdy_n));

  // ****************************************
  // helpers
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_time(input string what, input int exp, input int got);
    checks++;
    if (got < exp - 24 || got > exp + 24) begin
      num_errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wait_rdy(input int lim, output int n);
    n = 0;
    while (dout_rdy_n !== 1'b0 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic settle(input string what, input logic [23:0] v, input int exp);
    int n;
    i_ams_host_model.wr_mode(v);
    wait_rdy(exp + 200, n);
    chk_time(what, exp, n);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    logic [31:0] r;
    i_ams_host_model.rd(RS_MODE, 24, r);
    chk("mode reset", {8'h0, MODE_RESET}, r);
    i_ams_host_model.rd(RS_STATUS, 8, r);
    chk("status reset", 32'h80, r);
    i_ams_host_model.sel(1'b1);
    chk("oe selected", 32'h1, {31'h0, dout_oe});
    i_ams_host_model.shift(8, 32'h08, r);
    i_ams_host_model.shift(12, 32'hfff, r);
    i_ams_host_model.sel(1'b0);
    chk("oe released", 32'h0, {31'h0, dout_oe});
    i_ams_host_model.rd(RS_MODE, 24, r);
    chk("partial write", {8'h0, MODE_RESET}, r);
    $display("test reset done");
  endtask

  task automatic t_decode();
    logic [23:0] v;
    logic [31:0] r;
    logic [7:0]  e;
    logic [7:0]  g;
    for (int i = 0; i < 4; i++) begin
      v = {OPM_IDLE, 1'b0, 2'(i), 2'b0, i[0], 1'b0, i[1], 3'b001, (i[0] ? NOTCH50_CODE : 10'h1)};
      i_ams_host_model.wr_mode(v);
      i_ams_host_model.rd(RS_MODE, 24, r);
      chk("mode readback", {8'h0, v}, r);
      e = {1'b1, 1'b0, i == 0, i[1], i == 3, i[0], i[1], i[0]};
      g = {afe_ctrl.filter_reset, afe_ctrl.analog_pd, afe_ctrl.xtal_en, afe_ctrl.int_osc_en,
           afe_ctrl.mclk_b_oe, afe_ctrl.third_order, afe_ctrl.parity_on, afe_ctrl.notch_sixty_on};
      chk("ctrl decode", {24'h0, e}, {24'h0, g});
    end
    i_ams_host_model.wr_mode({OPM_PDOWN, 1'b0, CLK_XTAL, 18'h1});
    chk("pdown xtal", 32'h3, {30'h0, afe_ctrl.analog_pd, afe_ctrl.xtal_en});
    i_ams_host_model.wr_mode({OPM_PDOWN, 1'b0, CLK_INT, 18'h1});
    chk("pdown int", 32'h2, {30'h0, afe_ctrl.analog_pd, afe_ctrl.xtal_en});
    $display("test decode done");
  endtask

  task automatic t_cont();
    logic [31:0] r;
    int          n;
    afe_result = 24'hc0ffee;
    settle("sinc4", 24'h000001, 4096);
    i_ams_host_model.rd(RS_DATA, 24, r);
    chk("data", 32'hc0ffee, r);
    chk("ready after read", 32'h1, {31'h0, dout_rdy_n});
    wait_rdy(1100, n);
    chk("next result", 32'h1, {31'h0, n < 1100});
    settle("third_order_filter_sel", 24'h008001, 3072);
    settle("zero latency", 24'h000801, 1024);
    channel_enable_bits = 8'h03;
    settle("zl multi", 24'h000801, 4096);
    channel_enable_bits = 8'h01;
    chop_en = 1'b1;
    settle("chop", 24'h000001, 16384);
    chop_en = 1'b0;
    $display("test continuous done");
  endtask

  task automatic t_status();
    logic [31:0] r;
    int          n;
    afe_result = 24'h000007;
    result_channel_tag = 3'h5;
    settle("append", 24'h102001, 4096);
    i_ams_host_model.rd(RS_DATA, 32, r);
    chk("status odd", 32'h00000715, r);
    afe_result = 24'h000003;
    wait_rdy(1100, n);
    i_ams_host_model.rd(RS_DATA, 32, r);
    chk("status even", 32'h00000305, r);
    result_channel_tag = 3'h0;
    $display("test status done");
  endtask

  task automatic t_single();
    logic [31:0] r;
    afe_result = 24'h5a5a5a;
    settle("single", {OPM_SINGLE, 9'h0, 1'b1, 11'h1}, WAKE + 4096);
    cyc(600);
    chk("single hold", 32'h1, {31'h0, dout_rdy_n === 1'b0 && afe_ctrl.analog_pd === 1'b1});
    i_ams_host_model.rd(RS_DATA, 24, r);
    chk("single data", 32'h5a5a5a, r);
    $display("test single done");
  endtask

  task automatic t_cal();
    logic [31:0] r;
    logic [2:0]  m;
    int          n;
    for (int k = 4; k < 8; k++) begin
      m = 3'(k);
      i_ams_host_model.wr_mode({m, 21'h1});
      r = {29'h0, dout_rdy_n, afe_ctrl.input_short, afe_ctrl.fs_connect};
      chk("cal start", {29'h0, 1'b1, m == 3'h4, m == 3'h5}, r);
      n = 0;
      while (cal_store !== 1'b1 && n < 5000) begin
        cyc(1);
        n++;
      end
      chk_time("cal time", 4096, n);
      chk("cal kind", {31'h0, m[0]}, {31'h0, cal_is_gain});
      cyc(3);
      chk("cal ready", 32'h0, {31'h0, dout_rdy_n});
      i_ams_host_model.rd(RS_MODE, 24, r);
      chk("cal to idle", {8'h0, OPM_IDLE, 21'h1}, r);
    end
    $display("test calibration done");
  endtask

  task automatic t_continuous_read_en();
    logic [31:0] r;
    afe_result = 24'ha5c3f0;
    settle("continuous_read_en setup", 24'h000801, 1024);
    i_ams_host_model.sel(1'b1);
    i_ams_host_model.shift(8, {24'h0, CMD_CONTINUOUS_READ_EN_ON}, r);
    i_ams_host_model.shift(24, 32'h0, r);
    chk("continuous_read_en first", 32'ha5c3f0, r);
    afe_result = 24'h3c0f96;
    cyc(1100);
    i_ams_host_model.shift(24, 32'h0, r);
    chk("continuous_read_en stream", 32'h3c0f96, r);
    cyc(1100);
    i_ams_host_model.shift(8, {24'h0, CMD_CONTINUOUS_READ_EN_OFF}, r);
    i_ams_host_model.sel(1'b0);
    i_ams_host_model.rd(RS_MODE, 24, r);
    chk("continuous_read_en off", 32'h000801, r);
    $display("test continuous read done");
  endtask

  initial begin
    reset_n = 1'b0;
    chop_en = 1'b0;
    afe_err = 1'b0;
    channel_enable_bits = 8'h01;
    result_channel_tag = 3'h0;
    afe_result = 24'h0;
    cyc(3);
    reset_n = 1'b1;
    cyc(10);
    t_reset();
    t_decode();
    t_cont();
    t_status();
    t_single();
    t_cal();
    t_continuous_read_en();
    complete_run();
  end

  initial begin
    repeat (90000) @(posedge sys_clk);
    num_errors++;
    complete_run();
  end
endmodule
